// File: include/data_mem_pkg.sv
// Operation
// - Data memory is volatile, eight bits per location.
// - General area: 128 bytes, bank 0, 80H-FFH.
// - Every general location is readable and writable.
// - Special registers ignore bank; 40H needs bank 1.
// - Address space starts at 00H with special registers.
// - Unused special addresses read back as 00H.
// - Indirect port access goes to pointer's location.
// - Port 0 reaches bank 0; port 1 any bank.
// - Indirect port target: read 00H, write ignored.
// - Both pointers are real read/write registers.
// - Bank select bit 0 picks bank 0 or 1.
// - Bank select bits 7 to 1 read zero.
// - Reset clears bank, except watchdog reset in power-down.
// - Direct addressing always reaches bank 0.
// - Accumulator holds results; no memory-to-memory moves.
// - Program counter low write jumps within page.
// - Program counter low write inserts a dummy cycle.
package data_mem_pkg;

  // Width of one data memory location.
  localparam int DATA_W = 8;
  // Width of an effective address: bank bit above an 8-bit address.
  localparam int EFF_W = 9;
  // Number of general purpose locations.
  localparam int GP_DEPTH = 128;
  // Address width inside the general purpose area.
  localparam int GP_AW = 7;

  // Special function register addresses.
  localparam logic [7:0] ADDR_IND_PORT0 = 8'h00;
  localparam logic [7:0] ADDR_MEM_PTR0 = 8'h01;
  localparam logic [7:0] ADDR_IND_PORT1 = 8'h02;
  localparam logic [7:0] ADDR_MEM_PTR1 = 8'h03;
  localparam logic [7:0] ADDR_BANK_SEL = 8'h04;
  localparam logic [7:0] ADDR_ALU_RESULT = 8'h05;
  localparam logic [7:0] ADDR_PC_LOW = 8'h06;
  // Nonvolatile control register, present in bank 1 only.
  localparam logic [7:0] ADDR_NV_CTRL = 8'h40;

  // Bit that splits the special area from the general area.
  localparam int GP_AREA_BIT = 7;
  // Position of the bank select bit in its register.
  localparam int BANK_BIT_POS = 0;

  // Values after reset.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic RST_BANK = 1'b0;
  // Value returned by unused or unreachable locations.
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Cycles from a taken read to its data.
  localparam int READ_LATENCY = 2;

  // Source selected for a pending read.
  typedef enum logic [2:0] {
    SRC_ZERO,
    SRC_RAM,
    SRC_PERIPH,
    SRC_PTR0,
    SRC_PTR1,
    SRC_BANK,
    SRC_ALU,
    SRC_PC_LOW
  } rd_src_t;

endpackage : data_mem_pkg

// File: verilog/gp_data_ram.sv
`timescale 1ns/1ps
`default_nettype none

// General purpose storage array with a registered read port.
module gp_data_ram (
  // Clock.
  input wire logic i_core_clk,
  // Write port.
  input wire logic i_wr,
  input wire logic [data_mem_pkg::GP_AW-1:0] i_wr_addr,
  input wire logic [data_mem_pkg::DATA_W-1:0] i_wdata,
  // Read port.
  input wire logic i_rd,
  input wire logic [data_mem_pkg::GP_AW-1:0] i_rd_addr,
  output logic [data_mem_pkg::DATA_W-1:0] o_rdata
);

  // The storage itself; contents are undefined after power-up.
  logic [data_mem_pkg::DATA_W-1:0] mem [data_mem_pkg::GP_DEPTH];

  // Every location takes a write; none is protected.
  always_ff @(posedge i_core_clk) begin
    if (i_wr) begin
      mem[i_wr_addr] <= i_wdata;
    end
  end

  // Read data is captured whole, one byte per location.
  always_ff @(posedge i_core_clk) begin
    if (i_rd) begin
      o_rdata <= mem[i_rd_addr];
    end
  end

endmodule : gp_data_ram

`default_nettype wire

// File: verilog/banked_data_memory_access.sv
`timescale 1ns/1ps
`default_nettype none

// Data memory access path: resolves direct and indirect operands to a
// banked effective address, keeps the pointer, bank, accumulator and
// counter low jump registers, owns the general purpose array and forwards the other special
// addresses to the peripheral registers outside, 40H only in bank 1.
module banked_data_memory_access (
  // Clock and power-on reset.
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Other resets, synchronous one-cycle pulses from the reset logic.
  input wire logic i_sys_reset,
  input wire logic i_wdt_pd_reset,
  // Data memory operand access from the core.
  input wire logic i_mem_rd,
  input wire logic i_mem_wr,
  input wire logic [7:0] i_mem_addr,
  input wire logic [7:0] i_mem_wdata,
  output logic [7:0] o_mem_rdata,
  output logic o_mem_rvalid,
  // Result load from the arithmetic unit.
  input wire logic i_alu_load,
  input wire logic [7:0] i_alu_data,
  output logic [7:0] o_alu_result,
  // Program counter low byte.
  input wire logic [7:0] i_pc_low,
  output logic o_pc_jump,
  output logic [7:0] o_pc_jump_low,
  output logic o_dummy_cycle,
  // Peripheral special registers outside this block.
  output logic o_periph_rd,
  output logic o_periph_wr,
  output logic [6:0] o_periph_addr,
  output logic o_periph_bank,
  output logic [7:0] o_periph_wdata,
  input wire logic [7:0] i_periph_rdata,
  input wire logic i_periph_hit,
  // Register state seen by the core.
  output logic o_bank_sel,
  output logic [7:0] o_mem_ptr0,
  output logic [7:0] o_mem_ptr1
);

  // A write wins over a read requested in the same cycle.
  wire logic wr_take;
  wire logic rd_take;
  assign wr_take = i_mem_wr;
  assign rd_take = i_mem_rd & ~i_mem_wr;

  // The operand names one of the two indirect ports.
  wire logic is_port0;
  wire logic is_port1;
  assign is_port0 = (i_mem_addr == data_mem_pkg::ADDR_IND_PORT0);
  assign is_port1 = (i_mem_addr == data_mem_pkg::ADDR_IND_PORT1);

  // Effective address: bank bit over the byte address.
  wire logic [data_mem_pkg::EFF_W-1:0] eff_addr;
  assign eff_addr = is_port0 ? {1'b0, o_mem_ptr0} :
                    is_port1 ? {o_bank_sel, o_mem_ptr1} :
                    {1'b0, i_mem_addr};

  // Low byte and bank of the effective address.
  wire logic [7:0] eff_low;
  wire logic eff_bank;
  assign eff_low = eff_addr[7:0];
  assign eff_bank = eff_addr[data_mem_pkg::EFF_W-1];

  // An indirect access that points back at a port reaches nothing.
  wire logic null_tgt;
  assign null_tgt = (is_port0 | is_port1) &
                    ((eff_low == data_mem_pkg::ADDR_IND_PORT0) |
                     (eff_low == data_mem_pkg::ADDR_IND_PORT1));

  // General area lies in the upper half, and only in bank 0.
  wire logic sel_ram;
  assign sel_ram = ~null_tgt & eff_low[data_mem_pkg::GP_AREA_BIT] & ~eff_bank;

  // Special area starts at address zero and ignores the bank.
  wire logic in_sfr;
  assign in_sfr = ~null_tgt & ~eff_low[data_mem_pkg::GP_AREA_BIT];

  // Registers kept inside this block.
  wire logic sel_ptr0;
  wire logic sel_ptr1;
  wire logic sel_bank;
  wire logic sel_alu;
  wire logic sel_pcl;
  assign sel_ptr0 = in_sfr & (eff_low == data_mem_pkg::ADDR_MEM_PTR0);
  assign sel_ptr1 = in_sfr & (eff_low == data_mem_pkg::ADDR_MEM_PTR1);
  assign sel_bank = in_sfr & (eff_low == data_mem_pkg::ADDR_BANK_SEL);
  assign sel_alu = in_sfr & (eff_low == data_mem_pkg::ADDR_ALU_RESULT);
  assign sel_pcl = in_sfr & (eff_low == data_mem_pkg::ADDR_PC_LOW);

  // Any special address not kept here is passed outside; the nonvolatile
  // control register answers only in bank 1.
  wire logic sel_internal;
  wire logic is_nv_ctrl;
  wire logic sel_periph;
  assign sel_internal = sel_ptr0 | sel_ptr1 | sel_bank | sel_alu | sel_pcl;
  assign is_nv_ctrl = (eff_low == data_mem_pkg::ADDR_NV_CTRL);
  assign sel_periph = in_sfr & ~sel_internal & (~is_nv_ctrl | eff_bank);

  // Source for a read taken in this cycle.
  wire data_mem_pkg::rd_src_t next_src;
  assign next_src = sel_ram ? data_mem_pkg::SRC_RAM :
                    sel_periph ? data_mem_pkg::SRC_PERIPH :
                    sel_ptr0 ? data_mem_pkg::SRC_PTR0 :
                    sel_ptr1 ? data_mem_pkg::SRC_PTR1 :
                    sel_bank ? data_mem_pkg::SRC_BANK :
                    sel_alu ? data_mem_pkg::SRC_ALU :
                    sel_pcl ? data_mem_pkg::SRC_PC_LOW :
                    data_mem_pkg::SRC_ZERO;

  // Strobes into the general purpose array.
  wire logic ram_wr;
  wire logic ram_rd;
  assign ram_wr = wr_take & sel_ram;
  assign ram_rd = rd_take & sel_ram;

  // Read data from the array, valid one cycle after the request.
  logic [7:0] ram_rdata;

  // The general purpose array, indexed by the low seven address bits.
  gp_data_ram u_gp_ram (
    .i_core_clk(i_core_clk),
    .i_wr(ram_wr),
    .i_wr_addr(eff_low[data_mem_pkg::GP_AW-1:0]),
    .i_wdata(i_mem_wdata),
    .i_rd(ram_rd),
    .i_rd_addr(eff_low[data_mem_pkg::GP_AW-1:0]),
    .o_rdata(ram_rdata)
  );

  // Memory pointers are ordinary registers; the core increments or
  // decrements them by read, modify and write.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_mem_ptr0 <= data_mem_pkg::RST_BYTE;
      o_mem_ptr1 <= data_mem_pkg::RST_BYTE;
    end else begin
      if (wr_take && sel_ptr0) begin
        o_mem_ptr0 <= i_mem_wdata;
      end
      if (wr_take && sel_ptr1) begin
        o_mem_ptr1 <= i_mem_wdata;
      end
    end
  end

  // Bank select: a watchdog reset while powered down keeps the bank.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_bank_sel <= data_mem_pkg::RST_BANK;
    end else if (i_sys_reset && !i_wdt_pd_reset) begin
      o_bank_sel <= data_mem_pkg::RST_BANK;
    end else if (i_sys_reset) begin
      o_bank_sel <= o_bank_sel;
    end else if (wr_take && sel_bank) begin
      o_bank_sel <= i_mem_wdata[data_mem_pkg::BANK_BIT_POS];
    end
  end

  // Accumulator: the arithmetic unit's load wins over an operand write.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_alu_result <= data_mem_pkg::RST_BYTE;
    end else if (i_alu_load) begin
      o_alu_result <= i_alu_data;
    end else if (wr_take && sel_alu) begin
      o_alu_result <= i_mem_wdata;
    end
  end

  // A write to the counter low byte becomes a jump inside the current
  // page; the core keeps the upper counter bits as they are.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pc_jump <= 1'b0;
      o_pc_jump_low <= data_mem_pkg::RST_BYTE;
    end else begin
      o_pc_jump <= wr_take & sel_pcl;
      if (wr_take && sel_pcl) begin
        o_pc_jump_low <= i_mem_wdata;
      end
    end
  end

  // The cycle after the jump is a dummy cycle while the new fetch starts.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_dummy_cycle <= 1'b0;
    end else begin
      o_dummy_cycle <= o_pc_jump;
    end
  end

  // Peripheral strobes are registered and last one cycle.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_periph_rd <= 1'b0;
      o_periph_wr <= 1'b0;
      o_periph_addr <= 7'h00;
      o_periph_bank <= 1'b0;
      o_periph_wdata <= data_mem_pkg::RST_BYTE;
    end else begin
      o_periph_rd <= rd_take & sel_periph;
      o_periph_wr <= wr_take & sel_periph;
      if ((rd_take || wr_take) && sel_periph) begin
        o_periph_addr <= eff_low[6:0];
        o_periph_bank <= eff_bank;
        o_periph_wdata <= i_mem_wdata;
      end
    end
  end

  // Pending read: which source answers in the next cycle.
  logic rd_pend;
  data_mem_pkg::rd_src_t rd_src;

  // The first stage of a read records its source.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_pend <= 1'b0;
      rd_src <= data_mem_pkg::SRC_ZERO;
    end else begin
      rd_pend <= rd_take;
      if (rd_take) begin
        rd_src <= next_src;
      end
    end
  end

  // Read selection in the second stage; a missing peripheral reads zero.
  logic [7:0] rd_mux;
  always_comb begin
    unique case (rd_src)
      data_mem_pkg::SRC_ZERO: rd_mux = data_mem_pkg::ZERO_BYTE;
      data_mem_pkg::SRC_RAM: rd_mux = ram_rdata;
      data_mem_pkg::SRC_PERIPH: rd_mux = i_periph_hit ? i_periph_rdata : data_mem_pkg::ZERO_BYTE;
      data_mem_pkg::SRC_PTR0: rd_mux = o_mem_ptr0;
      data_mem_pkg::SRC_PTR1: rd_mux = o_mem_ptr1;
      data_mem_pkg::SRC_BANK: rd_mux = {7'h00, o_bank_sel};
      data_mem_pkg::SRC_ALU: rd_mux = o_alu_result;
      data_mem_pkg::SRC_PC_LOW: rd_mux = i_pc_low;
    endcase
  end

  // Read data stands until the next read completes.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_mem_rvalid <= 1'b0;
      o_mem_rdata <= data_mem_pkg::RST_BYTE;
    end else begin
      o_mem_rvalid <= rd_pend;
      if (rd_pend) begin
        o_mem_rdata <= rd_mux;
      end
    end
  end

  // Checks on the access path.
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);

  // Every taken read answers exactly two cycles later, and nothing else does;
  // back-to-back reads give back-to-back answers.
  a_read_two_cycles: assert property (o_mem_rvalid == $past(rd_take, 2))
    else $error("read answer not two cycles after request");

  // Unused special addresses read back zero.
  a_unused_reads_zero: assert property (
    rd_take && in_sfr && next_src == data_mem_pkg::SRC_ZERO |-> ##2 o_mem_rdata == 8'h00)
    else $error("unused special address read not zero");

  // Indirect access that points at a port reads zero.
  a_null_read_zero: assert property (rd_take && null_tgt |-> ##2 o_mem_rdata == 8'h00)
    else $error("indirect read of a port not zero");

  // Indirect write that points at a port changes nothing.
  a_null_write_none: assert property (
    wr_take && null_tgt && !i_sys_reset |-> !ram_wr ##1
      ($stable(o_mem_ptr0) && $stable(o_mem_ptr1) && $stable(o_bank_sel) && !o_periph_wr))
    else $error("indirect write of a port had an effect");

  // Bank register reads with its upper bits zero.
  a_bank_upper_zero: assert property (
    rd_take && sel_bank |-> ##2 o_mem_rdata[7:1] == 7'h00)
    else $error("bank select upper bits not zero");

  // Writing the bank register takes bit 0.
  a_bank_write: assert property (
    wr_take && sel_bank && !i_sys_reset |=> o_bank_sel == $past(i_mem_wdata[0]))
    else $error("bank select not loaded from bit 0");

  // Ordinary reset returns to bank 0; watchdog reset when powered down holds.
  a_bank_reset: assert property (
    i_sys_reset |=> (o_bank_sel == ($past(i_wdt_pd_reset) ? $past(o_bank_sel) : 1'b0)))
    else $error("bank select wrong after reset");

  // Direct operands in the upper half always reach bank 0 storage.
  a_direct_bank0: assert property (
    wr_take && !is_port0 && !is_port1 && i_mem_addr[7] |-> ram_wr)
    else $error("direct write missed bank 0 storage");

  // Port 1 with bank 1 above the special area reaches no storage.
  a_port1_bank1: assert property (
    wr_take && is_port1 && o_bank_sel && o_mem_ptr1[7] |-> !ram_wr)
    else $error("bank 1 write reached bank 0 storage");

  // Nonvolatile control register is only reached in bank 1.
  a_nv_ctrl_bank: assert property (
    (o_periph_rd || o_periph_wr) && o_periph_addr == 7'h40 |-> o_periph_bank)
    else $error("nonvolatile control reached outside bank 1");

  // Counter low write gives a jump, then one dummy cycle.
  a_pc_jump_dummy: assert property (
    wr_take && sel_pcl |=> o_pc_jump && o_pc_jump_low == $past(i_mem_wdata)
      ##1 o_dummy_cycle && !o_pc_jump)
    else $error("program counter low write not followed by jump and dummy");

  // Scenarios worth seeing.
  c_pc_jump: cover property (o_pc_jump ##1 o_dummy_cycle);
  c_nv_ctrl_access: cover property (o_periph_wr && o_periph_bank && o_periph_addr == 7'h40);
  c_null_read: cover property (rd_take && null_tgt);
  c_bank_hold: cover property (i_sys_reset && i_wdt_pd_reset && o_bank_sel);

endmodule : banked_data_memory_access

`default_nettype wire

// File: testbench/periph_model.sv
`timescale 1ns/1ps
`default_nettype none

// Stand-in for the special registers outside the access block.
module periph_model (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Strobes and qualifiers from the access block.
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [6:0] i_addr,
  input wire logic i_bank,
  input wire logic [7:0] i_wdata,
  // Answer to the access block.
  output logic [7:0] o_rdata,
  output logic o_hit
);
  // Example data register, present in every bank.
  logic [7:0] data_reg;
  // Nonvolatile control register.
  logic [7:0] nv_ctrl;
  // Last value driven, so an idle bus shows its inverse.
  logic [7:0] last_q;
  // The data register answers in any bank.
  wire logic hit_data = (i_addr == 7'h1E);
  // The control register answers only in bank 1.
  wire logic hit_nv = (i_addr == 7'h40) && i_bank;
  // Unknown addresses give no hit, so the block must return zero.
  assign o_hit = hit_data || hit_nv;
  // Outside a read, or without a hit, the bus carries no stale value.
  wire logic [7:0] sel_data = hit_data ? data_reg : nv_ctrl;
  assign o_rdata = (i_rd && o_hit) ? sel_data : ~last_q;

  // Register writes and the idle pattern.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      data_reg <= 8'h00;
      nv_ctrl <= 8'h00;
      last_q <= 8'h00;
    end else begin
      if (i_wr && hit_data) data_reg <= i_wdata;
      if (i_wr && hit_nv) nv_ctrl <= i_wdata;
      last_q <= o_rdata;
    end
  end
endmodule : periph_model

`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the banked data memory access block.
module tb;
  // Stimulus driven by the bench.
  logic i_core_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_sys_reset = 1'b0, i_wdt_pd_reset = 1'b0, i_mem_rd = 1'b0, i_mem_wr = 1'b0;
  logic i_alu_load = 1'b0;
  logic [7:0] i_mem_addr = 8'h00, i_mem_wdata = 8'h00, i_alu_data = 8'h00, i_pc_low = 8'h00;
  // Outputs of the block and answers of the model.
  logic [7:0] o_mem_rdata, o_alu_result, o_pc_jump_low, o_periph_wdata, i_periph_rdata;
  logic [7:0] o_mem_ptr0, o_mem_ptr1;
  logic [6:0] o_periph_addr;
  logic o_mem_rvalid, o_pc_jump, o_dummy_cycle, o_periph_rd, o_periph_wr;
  logic o_periph_bank, i_periph_hit, o_bank_sel;
  // Counters for the verdict.
  int n_errors = 0;
  int comparisons = 0;

  banked_data_memory_access dut (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_sys_reset(i_sys_reset),
    .i_wdt_pd_reset(i_wdt_pd_reset), .i_mem_rd(i_mem_rd), .i_mem_wr(i_mem_wr),
    .i_mem_addr(i_mem_addr), .i_mem_wdata(i_mem_wdata), .o_mem_rdata(o_mem_rdata),
    .o_mem_rvalid(o_mem_rvalid), .i_alu_load(i_alu_load), .i_alu_data(i_alu_data),
    .o_alu_result(o_alu_result), .i_pc_low(i_pc_low), .o_pc_jump(o_pc_jump),
    .o_pc_jump_low(o_pc_jump_low), .o_dummy_cycle(o_dummy_cycle),
    .o_periph_rd(o_periph_rd), .o_periph_wr(o_periph_wr), .o_periph_addr(o_periph_addr),
    .o_periph_bank(o_periph_bank), .o_periph_wdata(o_periph_wdata),
    .i_periph_rdata(i_periph_rdata), .i_periph_hit(i_periph_hit),
    .o_bank_sel(o_bank_sel), .o_mem_ptr0(o_mem_ptr0), .o_mem_ptr1(o_mem_ptr1));

  periph_model partner (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_rd(o_periph_rd), .i_wr(o_periph_wr),
    .i_addr(o_periph_addr), .i_bank(o_periph_bank), .i_wdata(o_periph_wdata),
    .o_rdata(i_periph_rdata), .o_hit(i_periph_hit));

  // Clock of 20 ns period.
  always #10 i_core_clk = ~i_core_clk;

  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // One operand write, taken at the second edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_mem_wr <= 1'b1;
    i_mem_addr <= a;
    i_mem_wdata <= d;
    @(posedge i_core_clk);
    i_mem_wr <= 1'b0;
  endtask : wr

  // One operand read; the answer must stand one cycle after the taking edge.
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_core_clk);
    i_mem_rd <= 1'b1;
    i_mem_addr <= a;
    @(posedge i_core_clk);
    i_mem_rd <= 1'b0;
    @(posedge i_core_clk);
    #1;
    chk("rvalid", {7'h00, o_mem_rvalid}, 8'h01);
    chk(nm, o_mem_rdata, exp);
  endtask : rdchk

  // A synchronous reset pulse, optionally as a power-down watchdog reset.
  task automatic rst_pulse(input logic pd);
    @(posedge i_core_clk);
    i_sys_reset <= 1'b1;
    i_wdt_pd_reset <= pd;
    @(posedge i_core_clk);
    i_sys_reset <= 1'b0;
    i_wdt_pd_reset <= 1'b0;
    #1;
  endtask : rst_pulse

  // Register values straight after power-on reset.
  task automatic t_reset();
    #1;
    chk("ptr0", o_mem_ptr0, 8'h00);
    chk("ptr1", o_mem_ptr1, 8'h00);
    chk("bank", {7'h00, o_bank_sel}, 8'h00);
    rdchk("bank_reg", 8'h04, 8'h00);
  endtask : t_reset

  // General area edges and the last special address below it.
  task automatic t_gp();
    wr(8'h80, 8'hA5);
    wr(8'hFF, 8'h5A);
    wr(8'h7F, 8'h33);
    rdchk("gp_80", 8'h80, 8'hA5);
    rdchk("gp_ff", 8'hFF, 8'h5A);
    rdchk("sf_7f", 8'h7F, 8'h00);
    rdchk("sf_19", 8'h19, 8'h00);
  endtask : t_gp

  // Pointers and indirect access in bank 0.
  task automatic t_ptr();
    wr(8'h01, 8'h80);
    #1;
    chk("ptr0", o_mem_ptr0, 8'h80);
    wr(8'h00, 8'hC3);
    rdchk("via_port0", 8'h80, 8'hC3);
    rdchk("ptr0_rd", 8'h01, 8'h80);
    wr(8'h03, 8'hFF);
    #1;
    chk("ptr1", o_mem_ptr1, 8'hFF);
    rdchk("via_port1", 8'h02, 8'h5A);
  endtask : t_ptr

  // Bank selection and what each addressing mode reaches.
  task automatic t_bank();
    wr(8'h04, 8'hFF);
    #1;
    chk("bank_bit", {7'h00, o_bank_sel}, 8'h01);
    rdchk("bank_reg", 8'h04, 8'h01);
    rdchk("p1_bank1", 8'h02, 8'h00);
    wr(8'h02, 8'h77);
    rdchk("p0_bank1", 8'h00, 8'hC3);
    rdchk("direct_ff", 8'hFF, 8'h5A);
    wr(8'h04, 8'h00);
    rdchk("p1_bank0", 8'h02, 8'h5A);
  endtask : t_bank

  // The control register at 40H, reached only through port 1 in bank 1.
  task automatic t_nvc();
    wr(8'h03, 8'h40);
    wr(8'h04, 8'h01);
    wr(8'h02, 8'h9C);
    #1;
    chk("pwr", {7'h00, o_periph_wr}, 8'h01);
    chk("paddr", {1'b0, o_periph_addr}, 8'h40);
    chk("pbank", {7'h00, o_periph_bank}, 8'h01);
    chk("pwdata", o_periph_wdata, 8'h9C);
    rdchk("nv_rd", 8'h02, 8'h9C);
    rdchk("nv_direct", 8'h40, 8'h00);
    wr(8'h1E, 8'h21);
    rdchk("sf_bank1", 8'h1E, 8'h21);
    // A read of an outside register must raise the read strobe for one cycle.
    @(posedge i_core_clk);
    i_mem_rd <= 1'b1;
    i_mem_addr <= 8'h1E;
    @(posedge i_core_clk);
    i_mem_rd <= 1'b0;
    #1;
    chk("prd", {7'h00, o_periph_rd}, 8'h01);
    wr(8'h04, 8'h00);
    rdchk("nv_bank0", 8'h02, 8'h00);
  endtask : t_nvc

  // Indirect access that names a port itself.
  task automatic t_ind();
    wr(8'h01, 8'h02);
    rdchk("port_ind", 8'h00, 8'h00);
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h11);
    #1;
    chk("ptr0_kept", o_mem_ptr0, 8'h00);
    chk("pwr_null", {7'h00, o_periph_wr}, 8'h00);
    rdchk("port_ind0", 8'h00, 8'h00);
  endtask : t_ind

  // Accumulator loads, and the load winning over a write at the same edge.
  task automatic t_acc();
    wr(8'h05, 8'hE1);
    rdchk("acc_wr", 8'h05, 8'hE1);
    @(posedge i_core_clk);
    i_alu_load <= 1'b1;
    i_alu_data <= 8'h4B;
    i_mem_wr <= 1'b1;
    i_mem_addr <= 8'h05;
    i_mem_wdata <= 8'h99;
    @(posedge i_core_clk);
    i_alu_load <= 1'b0;
    i_mem_wr <= 1'b0;
    #1;
    chk("acc_alu", o_alu_result, 8'h4B);
  endtask : t_acc

  // Program counter low write: jump, then one dummy cycle.
  task automatic t_pcl();
    @(posedge i_core_clk);
    i_pc_low <= 8'h2D;
    wr(8'h06, 8'h77);
    #1;
    chk("jump", {7'h00, o_pc_jump}, 8'h01);
    chk("jump_low", o_pc_jump_low, 8'h77);
    chk("dummy0", {7'h00, o_dummy_cycle}, 8'h00);
    @(posedge i_core_clk);
    #1;
    chk("jump_end", {7'h00, o_pc_jump}, 8'h00);
    chk("dummy1", {7'h00, o_dummy_cycle}, 8'h01);
    rdchk("pcl_rd", 8'h06, 8'h2D);
  endtask : t_pcl

  // Bank after the various resets, one of them in mid-run.
  task automatic t_rst();
    wr(8'h04, 8'h01);
    rst_pulse(1'b1);
    chk("bank_wdt", {7'h00, o_bank_sel}, 8'h01);
    rst_pulse(1'b0);
    chk("bank_sys", {7'h00, o_bank_sel}, 8'h00);
    chk("acc_kept", o_alu_result, 8'h4B);
    wr(8'h04, 8'h01);
    @(posedge i_core_clk);
    i_arst_n <= 1'b0;
    @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    #1;
    chk("bank_por", {7'h00, o_bank_sel}, 8'h00);
    rdchk("gp_kept", 8'h80, 8'hC3);
  endtask : t_rst

  // Main sequence: reset for six cycles, then the scenarios.
  initial begin
    repeat (6) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    t_reset();
    t_gp();
    t_ptr();
    t_bank();
    t_nvc();
    t_ind();
    t_acc();
    t_pcl();
    t_rst();
    report_and_stop();
  end

  // Watchdog far beyond the roughly 126 cycles the scenarios need.
  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end
endmodule : tb

`default_nettype wire
